// ===== src/mlpc_top.sv
`timescale 1ns/10ps
module mlpc_top
  import mlpc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MLPC_CYC_PER_MS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dsr,
  input  wire logic        rlsd,
  input  wire logic        ri,
  input  wire logic        paper_out,
  input  wire logic        cover_open,
  input  wire logic        head_jam,
  output logic             dtr,
  output logic             rts,
  output logic             srts,
  output logic             txd_space,
  output logic             tx_en,
  output logic             rx_en,
  output logic             xoff_req
);

  logic [5:0]       pins_q;
  logic             dsr_q;
  logic             rlsd_q;
  logic             ri_q;
  logic             stop_q;
  logic             ri_prev_ff;
  logic             stop_prev_ff;
  logic [9:0]       ctrl_ff;
  logic [2:0]       mode;
  logic             cmd_brk;
  logic             cmd_long;
  logic [31:0]      ms_cnt_ff;
  logic             tick;
  mlpc_state_t      state_ff;
  mlpc_state_t      nxt_state;
  logic [15:0]      tmr_ff;
  logic [15:0]      qual_ff;
  logic [15:0]      ring_tmr_ff;
  logic             ring_arm_ff;
  logic             stop_evt;
  logic             disc_pend_ff;
  logic             brk_pend_ff;
  logic             brk_act_ff;
  logic [15:0]      brk_tmr_ff;
  logic             line_up;
  logic             fdx_plain;
  logic             hold_state;
  logic [MLPC_EVT_W-1:0] evt_ff;
  logic [MLPC_EVT_W-1:0] evt_set;
  logic             wr_acc;
  logic             setup;
  logic             addr_ok;

  mlpc_sync #(
    .W (6)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({head_jam, cover_open, paper_out, ri, rlsd, dsr}),
    .q       (pins_q)
  );

  assign dsr_q  = pins_q[0];
  assign rlsd_q = pins_q[1];
  assign ri_q   = pins_q[2];
  assign stop_q = |pins_q[5:3];
  assign mode      = ctrl_ff[MLPC_CTRL_MODE_HI:MLPC_CTRL_MODE_LO];
  assign fdx_plain = (mode == MLPC_MODE_FDX_PLAIN);

  // APB: zero wait states, so pready is constant high.
  assign pready  = 1'b1;
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign addr_ok = (paddr == MLPC_OFF_CTRL) || (paddr == MLPC_OFF_CMD) ||
                   (paddr == MLPC_OFF_STAT) || (paddr == MLPC_OFF_EVT);
  assign pslverr = psel && penable && !addr_ok;
  assign cmd_brk  = wr_acc && (paddr == MLPC_OFF_CMD) && pwdata[MLPC_CMD_BREAK];
  assign cmd_long = wr_acc && (paddr == MLPC_OFF_CMD) && pwdata[MLPC_CMD_LONG];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= MLPC_CTRL_RST;
    end else if (wr_acc && (paddr == MLPC_OFF_CTRL)) begin
      ctrl_ff <= pwdata[9:0];
    end
  end

  // Read data is captured in the setup phase and stands through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup) begin
      unique case (paddr)
        MLPC_OFF_CTRL: prdata <= {22'h0, ctrl_ff};
        MLPC_OFF_STAT: prdata <= {19'h0, brk_act_ff, brk_pend_ff, ri_q, rlsd_q, dsr_q,
                                  rx_en, tx_en, rts, dtr, 1'b0, state_ff};
        MLPC_OFF_EVT:  prdata <= {27'h0, evt_ff};
        default:       prdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_ff <= 32'h0;
    end else if (tick) begin
      ms_cnt_ff <= 32'h0;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 32'h1;
    end
  end
  assign tick = (ms_cnt_ff == 32'(CYC_PER_MS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ri_prev_ff   <= 1'b0;
      stop_prev_ff <= 1'b0;
    end else begin
      ri_prev_ff   <= ri_q;
      stop_prev_ff <= stop_q;
    end
  end

  assign stop_evt = stop_q && !stop_prev_ff;

  assign line_up = (state_ff == ST_CONNECTED) || (state_ff == ST_FDX_PLAIN);
  assign hold_state = (state_ff == ST_DISC) || (state_ff == ST_LONG_BRK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_pend_ff <= 1'b0;
    end else begin
      disc_pend_ff <= stop_evt && ctrl_ff[MLPC_CTRL_AUTO_DC] && !fdx_plain &&
                      (state_ff != ST_LOCAL) && !hold_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xoff_req <= 1'b0;
    end else begin
      xoff_req <= stop_evt && ctrl_ff[MLPC_CTRL_XON_EN] && line_up;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_LOCAL: begin
        if (ctrl_ff[MLPC_CTRL_ONLINE] && fdx_plain) begin
          nxt_state = ST_FDX_PLAIN;
        end else if (ctrl_ff[MLPC_CTRL_ONLINE] && (mode >= MLPC_MODE_FDX_MODEM) &&
                     (mode <= MLPC_MODE_HDX_ETX)) begin
          nxt_state = ST_WAIT_DSR;
        end
      end
      ST_FDX_PLAIN: begin
        if (!ctrl_ff[MLPC_CTRL_ONLINE] || !fdx_plain) begin
          nxt_state = ST_LOCAL;
        end
      end
      ST_WAIT_DSR: begin
        if (dsr_q) begin
          nxt_state = ST_WAIT_RLSD;
        end else if (ring_arm_ff && (ring_tmr_ff >= MLPC_T_RING_MS)) begin
          nxt_state = ST_DISC;
        end
      end
      ST_WAIT_RLSD: begin
        if (qual_ff >= MLPC_T_RLSD_QUAL_MS) begin
          nxt_state = ST_CONNECTED;
        end else if (!dsr_q) begin
          nxt_state = ST_DISC;
        end else if (ctrl_ff[MLPC_CTRL_ORIG] && (tmr_ff >= MLPC_T_CARRIER_MS)) begin
          nxt_state = ST_DISC;
        end
      end
      ST_CONNECTED: begin
        if (!dsr_q || ri_q || (qual_ff >= MLPC_T_CARRIER_MS)) begin
          nxt_state = ST_DISC;
        end
      end
      ST_DISC: begin
        if (tmr_ff >= MLPC_T_DISC_MS) begin
          nxt_state = ST_LOCAL;
        end
      end
      ST_LONG_BRK: begin
        if (tmr_ff >= MLPC_T_LONG_BRK_MS) begin
          nxt_state = ST_LOCAL;
        end
      end
      default: nxt_state = ST_LOCAL;
    endcase
    if (!hold_state && (state_ff != ST_LOCAL) && (state_ff != ST_FDX_PLAIN)) begin
      if (!ctrl_ff[MLPC_CTRL_ONLINE] || fdx_plain || (mode > MLPC_MODE_HDX_ETX)) begin
        nxt_state = ST_LOCAL;
      end else if (disc_pend_ff) begin
        nxt_state = ST_DISC;
      end
    end
    if (cmd_long && !fdx_plain && ctrl_ff[MLPC_CTRL_ONLINE] && !hold_state) begin
      nxt_state = ST_LONG_BRK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_LOCAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // State timer in milliseconds, restarted on every state change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_ff <= 16'h0;
    end else if (nxt_state != state_ff) begin
      tmr_ff <= 16'h0;
    end else if (tick && (tmr_ff != 16'hffff)) begin
      tmr_ff <= tmr_ff + 16'h1;
    end
  end

  // Carrier qualifier: RLSD high time while waiting, RLSD low time once connected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_ff <= 16'h0;
    end else if (nxt_state != state_ff) begin
      qual_ff <= 16'h0;
    end else if ((state_ff == ST_WAIT_RLSD) && !rlsd_q) begin
      qual_ff <= 16'h0;
    end else if ((state_ff == ST_CONNECTED) && rlsd_q) begin
      qual_ff <= 16'h0;
    end else if (tick && (qual_ff != 16'hffff)) begin
      qual_ff <= qual_ff + 16'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_arm_ff <= 1'b0;
      ring_tmr_ff <= 16'h0;
    end else if ((state_ff != ST_WAIT_DSR) || dsr_q || rlsd_q || ri_q) begin
      ring_arm_ff <= 1'b0;
      ring_tmr_ff <= 16'h0;
    end else if (ri_prev_ff) begin
      ring_arm_ff <= 1'b1;
      ring_tmr_ff <= 16'h0;
    end else if (tick && ring_arm_ff && (ring_tmr_ff != 16'hffff)) begin
      ring_tmr_ff <= ring_tmr_ff + 16'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_pend_ff <= 1'b0;
    end else begin
      if (hold_state || (state_ff == ST_LOCAL) || (tx_en && !brk_act_ff)) begin
        brk_pend_ff <= 1'b0;
      end
      // A request in the same cycle as a clear is kept.
      if (cmd_brk || (stop_evt && !ctrl_ff[MLPC_CTRL_AUTO_DC] &&
                      !ctrl_ff[MLPC_CTRL_XON_EN] && ctrl_ff[MLPC_CTRL_BRK_EN])) begin
        brk_pend_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_act_ff <= 1'b0;
      brk_tmr_ff <= 16'h0;
    end else if (!line_up) begin
      brk_act_ff <= 1'b0;
      brk_tmr_ff <= 16'h0;
    end else if (brk_act_ff) begin
      if (brk_tmr_ff >= MLPC_T_BREAK_MS) begin
        brk_act_ff <= 1'b0;
      end else if (tick) begin
        brk_tmr_ff <= brk_tmr_ff + 16'h1;
      end
    end else if (brk_pend_ff && tx_en) begin
      brk_act_ff <= 1'b1;
      brk_tmr_ff <= 16'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr   <= 1'b0;
      rts   <= 1'b0;
      tx_en <= 1'b0;
      rx_en <= 1'b0;
    end else begin
      dtr   <= (state_ff == ST_FDX_PLAIN) || (state_ff == ST_WAIT_DSR) ||
               (state_ff == ST_WAIT_RLSD) || (state_ff == ST_CONNECTED);
      rts   <= (state_ff == ST_FDX_PLAIN) || (state_ff == ST_WAIT_RLSD) ||
               (state_ff == ST_CONNECTED);
      tx_en <= line_up;
      rx_en <= line_up;
    end
  end

  // Secondary line: restraint on stop when S is set, speed indicator otherwise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srts      <= 1'b0;
      txd_space <= 1'b0;
    end else begin
      srts      <= line_up && (ctrl_ff[MLPC_CTRL_SEC_CH] ? stop_q : ctrl_ff[MLPC_CTRL_HI_SPD]);
      txd_space <= brk_act_ff || (state_ff == ST_LONG_BRK);
    end
  end

  assign evt_set = {(nxt_state == ST_LONG_BRK) && (state_ff != ST_LONG_BRK),
                    stop_evt,
                    brk_pend_ff && tx_en && !brk_act_ff && line_up,
                    xoff_req,
                    (nxt_state == ST_DISC) && (state_ff != ST_DISC)};

  // Sticky events, write one to clear; a new event wins over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ff <= '0;
    end else if (wr_acc && (paddr == MLPC_OFF_EVT)) begin
      evt_ff <= (evt_ff & ~pwdata[MLPC_EVT_W-1:0]) | evt_set;
    end else begin
      evt_ff <= evt_ff | evt_set;
    end
  end

endmodule

// ===== src/mlpc_pkg.sv
package mlpc_pkg;

  localparam int unsigned MLPC_CLK_HZ     = 100000000;
  localparam int unsigned MLPC_MS_PER_S   = 1000;
  localparam int unsigned MLPC_CYC_PER_MS = MLPC_CLK_HZ / MLPC_MS_PER_S;

  localparam logic [15:0] MLPC_T_RLSD_QUAL_MS = 16'd300;
  localparam logic [15:0] MLPC_T_BREAK_MS     = 16'd220;
  localparam logic [15:0] MLPC_T_DISC_MS      = 16'd80;
  localparam logic [15:0] MLPC_T_LONG_BRK_MS  = 16'd3500;
  localparam logic [15:0] MLPC_T_RING_MS      = 16'd20000;
  localparam logic [15:0] MLPC_T_CARRIER_MS   = 16'd5000;

  localparam logic [7:0] MLPC_OFF_CTRL = 8'h00;
  localparam logic [7:0] MLPC_OFF_CMD  = 8'h04;
  localparam logic [7:0] MLPC_OFF_STAT = 8'h08;
  localparam logic [7:0] MLPC_OFF_EVT  = 8'h0c;

  localparam int unsigned MLPC_CTRL_MODE_LO = 0;
  localparam int unsigned MLPC_CTRL_MODE_HI = 2;
  localparam int unsigned MLPC_CTRL_BRK_EN  = 3;
  localparam int unsigned MLPC_CTRL_SEC_CH  = 4;
  localparam int unsigned MLPC_CTRL_AUTO_DC = 5;
  localparam int unsigned MLPC_CTRL_XON_EN  = 6;
  localparam int unsigned MLPC_CTRL_ONLINE  = 7;
  localparam int unsigned MLPC_CTRL_ORIG    = 8;
  localparam int unsigned MLPC_CTRL_HI_SPD  = 9;
  localparam logic [9:0]  MLPC_CTRL_RST     = 10'h001;

  localparam int unsigned MLPC_CMD_BREAK = 0;
  localparam int unsigned MLPC_CMD_LONG  = 1;

  localparam int unsigned MLPC_EVT_W = 5;

  localparam logic [2:0] MLPC_MODE_FDX_PLAIN = 3'h1;
  localparam logic [2:0] MLPC_MODE_FDX_MODEM = 3'h2;
  localparam logic [2:0] MLPC_MODE_HDX_SUPV  = 3'h3;
  localparam logic [2:0] MLPC_MODE_HDX_EOT   = 3'h4;
  localparam logic [2:0] MLPC_MODE_HDX_ETX   = 3'h5;

  typedef enum logic [2:0] {
    ST_LOCAL,
    ST_FDX_PLAIN,
    ST_WAIT_DSR,
    ST_WAIT_RLSD,
    ST_CONNECTED,
    ST_DISC,
    ST_LONG_BRK
  } mlpc_state_t;

endpackage

// ===== src/mlpc_sync.sv
`timescale 1ns/10ps
module mlpc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          q[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule

// ===== bench/mlpc_props.sv
`timescale 1ns/10ps
module mlpc_props #(
  parameter int unsigned CYC_PER_MS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic rlsd,
  input wire logic dtr,
  input wire logic rts,
  input wire logic txd_space,
  input wire logic tx_en,
  input wire logic rx_en,
  input wire logic xoff_req
);
  logic [15:0] rlsd_ff;
  logic [15:0] dlow_ff;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Saturating run lengths; the low count starts full so power-up is not a disconnect.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rlsd_ff <= 16'h0000;
    end else if (!rlsd) begin
      rlsd_ff <= 16'h0000;
    end else if (rlsd_ff != 16'hffff) begin
      rlsd_ff <= rlsd_ff + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlow_ff <= 16'hffff;
    end else if (dtr) begin
      dlow_ff <= 16'h0000;
    end else if (dlow_ff != 16'hffff) begin
      dlow_ff <= dlow_ff + 16'h0001;
    end
  end

  AST_LOCAL_AFTER_RESET: assert property ($rose(presetn) |-> !dtr && !rts && !tx_en && !rx_en)
    else $error("outputs not idle after reset");
  AST_TX_RX_TOGETHER: assert property (tx_en == rx_en)
    else $error("transmit and receive enables differ");
  AST_TX_NEEDS_LINE: assert property (tx_en |-> dtr && rts)
    else $error("transmit enabled without dtr and rts");
  AST_RTS_NEEDS_DTR: assert property (rts |-> dtr)
    else $error("rts up while dtr down");
  AST_QUALIFY: assert property ($rose(tx_en) && $past(rts) |-> rlsd_ff >= 299 * CYC_PER_MS)
    else $error("transmit enabled before carrier qualified");
  AST_DISC_LEN: assert property ($rose(dtr) |-> dlow_ff >= 79 * CYC_PER_MS)
    else $error("disconnect shorter than allowed");
  AST_XOFF_PULSE: assert property (xoff_req |=> !xoff_req)
    else $error("xoff request longer than one cycle");
  AST_BREAK_TX: assert property (txd_space && dtr |-> tx_en)
    else $error("break sent while transmit disabled");
  AST_ERR_ACCESS: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
endmodule

// ===== bench/mlpc_modem_model.sv
`timescale 1ns/10ps
module mlpc_modem_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       dtr,
  input  wire logic       rts,
  input  wire logic       answer,
  input  wire logic       carrier,
  input  wire logic [7:0] lat,
  output logic            dsr,
  output logic            rlsd
);
  logic [7:0] cnt_ff;

  // Data set ready follows dtr after a selectable answer latency.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 8'h00;
    end else if (!(dtr && answer)) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != 8'hff) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr  <= 1'b0;
      rlsd <= 1'b0;
    end else begin
      dsr  <= dtr && answer && (cnt_ff >= lat);
      rlsd <= dsr && rts && carrier;
    end
  end
endmodule

// ===== bench/mlpc_tb_top.sv
`timescale 1ns/10ps
module mlpc_tb_top;
  import mlpc_pkg::*;
  localparam int unsigned C = 2;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er;
  logic        dsr, rlsd, ri = 1'b0;
  logic        paper_out = 1'b0, cover_open = 1'b0, head_jam = 1'b0;
  logic        dtr, rts, srts, txd_space, tx_en, rx_en, xoff_req;
  logic        answer = 1'b0, carrier = 1'b0;
  int          errors = 0;
  int          n_tests = 0;

  always #5 pclk = ~pclk;

  mlpc_top #(.CYC_PER_MS(C)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dsr(dsr), .rlsd(rlsd), .ri(ri),
    .paper_out(paper_out), .cover_open(cover_open), .head_jam(head_jam), .dtr(dtr),
    .rts(rts), .srts(srts), .txd_space(txd_space), .tx_en(tx_en), .rx_en(rx_en),
    .xoff_req(xoff_req));

  mlpc_modem_model u_modem (.pclk(pclk), .presetn(presetn), .dtr(dtr), .rts(rts),
    .answer(answer), .carrier(carrier), .lat(8'h14), .dsr(dsr), .rlsd(rlsd));

  task automatic finish_test();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic t_reset();
    apb(1'b0, MLPC_OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    chk({dtr, rts, tx_en, rx_en, txd_space}, 5'h00);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, MLPC_OFF_CTRL, 32'h080 | m);
      cyc(10);
      chk(dtr, (m != 0) && (m < 6));
      apb(1'b1, MLPC_OFF_CTRL, 32'h001);
      // Offline spans a full disconnect time, as the dtr low-time check expects.
      cyc(90 * C);
    end
  endtask

  task automatic t_plain();
    apb(1'b1, MLPC_OFF_CTRL, 32'h0b1);
    cyc(10);
    chk({dtr, rts, tx_en, rx_en}, 4'hf);
    chk(srts, 1'b0);
    paper_out <= 1'b1;
    cyc(10);
    chk(srts, 1'b1);
    paper_out <= 1'b0;
    cyc(20);
    chk({dtr, tx_en, srts}, 3'h6);
    apb(1'b1, MLPC_OFF_CTRL, 32'h2a1);
    cyc(10);
    chk(srts, 1'b1);
    apb(1'b1, MLPC_OFF_CTRL, 32'h001);
    cyc(90 * C);
  endtask

  task automatic t_connect();
    answer <= 1'b1;
    apb(1'b1, MLPC_OFF_CTRL, 32'h082);
    cyc(12);
    chk({dtr, rts}, 2'h2);
    cyc(30);
    chk({dtr, rts}, 2'h3);
    carrier <= 1'b1;
    cyc(250 * C);
    chk(tx_en, 1'b0);
    cyc(60 * C);
    chk({tx_en, rx_en}, 2'h3);
    apb(1'b0, MLPC_OFF_STAT, 32'h0);
    chk(rd, 32'h0000_03f4);
  endtask

  task automatic t_break();
    apb(1'b1, MLPC_OFF_CMD, 32'h1);
    cyc(100 * C);
    chk(txd_space, 1'b1);
    cyc(130 * C);
    chk(txd_space, 1'b0);
  endtask

  task automatic t_stop();
    int n;
    n = 0;
    apb(1'b1, MLPC_OFF_CTRL, 32'h0c2);
    head_jam <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      n += xoff_req;
    end
    head_jam <= 1'b0;
    chk(n, 1);
    chk(dtr, 1'b1);
    n = 0;
    apb(1'b1, MLPC_OFF_CTRL, 32'h0e2);
    cover_open <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      n += xoff_req;
    end
    cover_open <= 1'b0;
    chk(n, 1);
    chk({dtr, rts, tx_en}, 3'h0);
    cyc(55 * C);
    chk(dtr, 1'b0);
    cyc(30 * C);
    chk(dtr, 1'b1);
    apb(1'b0, MLPC_OFF_EVT, 32'h0);
    chk(rd, 32'h0000_000f);
    apb(1'b1, MLPC_OFF_EVT, 32'h1f);
    apb(1'b0, MLPC_OFF_EVT, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_long();
    apb(1'b1, MLPC_OFF_CMD, 32'h2);
    cyc(10);
    chk({dtr, rts, txd_space}, 3'h1);
    cyc(3400 * C);
    chk(txd_space, 1'b1);
    cyc(120 * C);
    chk(txd_space, 1'b0);
  endtask

  task automatic t_ring();
    answer <= 1'b0;
    apb(1'b1, MLPC_OFF_CTRL, 32'h082);
    cyc(100 * C);
    chk({dtr, rts}, 2'h2);
    ri <= 1'b1;
    cyc(10);
    ri <= 1'b0;
    cyc(19990 * C);
    chk(dtr, 1'b1);
    cyc(20 * C);
    chk(dtr, 1'b0);
  endtask

  task automatic t_orig();
    answer <= 1'b1;
    carrier <= 1'b0;
    apb(1'b1, MLPC_OFF_CTRL, 32'h182);
    cyc(300);
    chk({dtr, rts}, 2'h3);
    cyc(4900 * C);
    chk(dtr, 1'b1);
    cyc(50 * C);
    chk(dtr, 1'b0);
  endtask

  initial begin
    cyc(3);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_plain();
    t_connect();
    t_break();
    t_stop();
    t_long();
    t_ring();
    t_orig();
    finish_test();
  end

  initial begin
    cyc(80000);
    errors++;
    finish_test();
  end
endmodule

bind mlpc_top mlpc_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pslverr(pslverr), .rlsd(rlsd), .dtr(dtr), .rts(rts),
  .txd_space(txd_space), .tx_en(tx_en), .rx_en(rx_en), .xoff_req(xoff_req));
